// file: rtl/servo_pi_switch_feedforward_sel.sv
// Top: P/PI switch decision and speed/torque feedforward source selection
// Summary of operation
// - Mode 0 (torque compare) by default; mode 4 fixes PI
// - Mode 0 compares torque reference to threshold
// - Mode 1 compares deviation counter to threshold
// - Mode 2 compares acceleration reference to threshold
// - Mode 3 compares speed reference to threshold
// - Above threshold gives P, else PI
// - Torque threshold 200 percent, no hysteresis
// - Speed source: internal, model, host, cubic
// - Torque source: internal, model, host, cubic
// - Speed ff: position differential times gain
// - Torque ff: speed differential, inertia, gain
// - Each internal path low-pass filtered
// - Torque variant: 0 general, 2 high-speed
// - Host offsets: signed 32 speed, 16 torque
// - Cubic source needs sub-mode set to -1
`timescale 1ns/1ps
module servo_pi_switch_feedforward_sel
    import ff_sel_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Restart strobe: latches the mode selections
    input wire logic restart,
    // Control-cycle sample strobe for the feedforward paths
    input wire logic sample,
    // Mode selections, taken only at restart
    input wire logic [2:0] p_pi_switch_mode_sel,
    input wire logic [1:0] speed_ff_source_sel,
    input wire logic [1:0] torque_ff_source_sel,
    input wire logic [1:0] torque_ff_variant_sel,
    input wire logic [1:0] model_follow_enable_sel,
    // Thresholds, gains and filter times, effective at once
    input wire logic [31:0] torque_ref_switch_threshold,
    input wire logic [31:0] deviation_switch_threshold,
    input wire logic [31:0] accel_ref_switch_threshold,
    input wire logic [31:0] speed_ref_switch_threshold,
    input wire logic [15:0] speed_ff_gain,
    input wire logic [7:0] speed_ff_filter_time,
    input wire logic [15:0] torque_ff_gain,
    input wire logic [7:0] torque_ff_filter_time,
    input wire logic [15:0] load_inertia_pct,
    // Loop quantities
    input wire logic signed [31:0] torque_ref,
    input wire logic signed [31:0] deviation_count,
    input wire logic signed [31:0] accel_ref,
    input wire logic signed [31:0] speed_ref,
    input wire logic signed [31:0] position_ref,
    // Alternative feedforward sources
    input wire logic signed [31:0] model_speed_ff,
    input wire logic signed [31:0] model_torque_ff,
    input wire logic signed [31:0] host_velocity_offset,
    input wire logic signed [15:0] host_torque_offset,
    input wire logic signed [31:0] cubic_speed_ff,
    input wire logic signed [31:0] cubic_torque_ff,
    input wire logic [15:0] interp_sub_mode,
    // Results
    output logic p_only_ctrl,
    output logic signed [31:0] speed_ff_out,
    output logic signed [31:0] torque_ff_out,
    output logic [2:0] active_pi_mode,
    output logic [1:0] active_speed_src,
    output logic [1:0] active_torque_src
);
    typedef struct packed {
        cfg_state_t state;
        logic [2:0] pi_mode;
        logic [1:0] spd_src;
        logic [1:0] trq_src;
        logic [1:0] trq_var;
        logic [1:0] mf_en;
        logic p_only;
        logic signed [31:0] spd_ff;
        logic signed [31:0] trq_ff;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;
    logic p_only_now;
    logic signed [31:0] spd_int;
    logic signed [31:0] trq_int;
    logic signed [31:0] trq_ref_src;
    logic cubic_ok;

    ff_path_if spd_if();
    ff_path_if trq_if();

    pi_switch u_pi (
        .mode(st.pi_mode),
        .torque_ref(torque_ref),
        .deviation(deviation_count),
        .accel_ref(accel_ref),
        .speed_ref(speed_ref),
        .t_torque(torque_ref_switch_threshold),
        .t_dev(deviation_switch_threshold),
        .t_accel(accel_ref_switch_threshold),
        .t_speed(speed_ref_switch_threshold),
        .p_only(p_only_now)
    );

    // Internal speed feedforward: d(position_ref) * gain, filtered
    assign spd_if.ref_in = position_ref;
    assign spd_if.gain = speed_ff_gain;
    assign spd_if.scale = 16'h0080;
    assign spd_if.filter_shift = speed_ff_filter_time;
    assign spd_if.sample = sample;

    // High-speed variant differentiates the acceleration-corrected reference, cutting lag at speed
    assign trq_ref_src = (st.trq_var == TQ_VAR_HIGHSPEED) ? (speed_ref + (accel_ref >>> 1)) : speed_ref;
    assign trq_if.ref_in = trq_ref_src;
    assign trq_if.gain = torque_ff_gain;
    assign trq_if.scale = load_inertia_pct;
    assign trq_if.filter_shift = torque_ff_filter_time;
    assign trq_if.sample = sample;

    ff_path u_spd (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .p(spd_if.path)
    );

    ff_path u_trq (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .p(trq_if.path)
    );

    assign spd_int = spd_if.ff_out;
    assign trq_int = trq_if.ff_out;
    assign cubic_ok = (interp_sub_mode == INTERP_CUBIC);

    always_comb begin
        next_st = st;
        next_st.state = restart ? CFG_LATCH : CFG_RUN;
        if (restart) begin
            next_st.pi_mode = p_pi_switch_mode_sel;
            next_st.spd_src = speed_ff_source_sel;
            next_st.trq_src = torque_ff_source_sel;
            next_st.trq_var = torque_ff_variant_sel;
            next_st.mf_en = model_follow_enable_sel;
        end
        next_st.p_only = p_only_now;
        case (st.spd_src)
            FF_SRC_INTERNAL: next_st.spd_ff = spd_int;
            // Model output is only meaningful once model following was enabled
            FF_SRC_MODEL: next_st.spd_ff = (st.mf_en != 2'h0) ? model_speed_ff : 32'h00000000;
            FF_SRC_HOST: next_st.spd_ff = host_velocity_offset;
            FF_SRC_CUBIC: next_st.spd_ff = cubic_ok ? cubic_speed_ff : 32'h00000000;
            default: next_st.spd_ff = 32'h00000000;
        endcase
        case (st.trq_src)
            FF_SRC_INTERNAL: next_st.trq_ff = trq_int;
            FF_SRC_MODEL: next_st.trq_ff = (st.mf_en != 2'h0) ? model_torque_ff : 32'h00000000;
            FF_SRC_HOST: next_st.trq_ff = 32'(host_torque_offset);
            FF_SRC_CUBIC: next_st.trq_ff = cubic_ok ? cubic_torque_ff : 32'h00000000;
            default: next_st.trq_ff = 32'h00000000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.pi_mode <= PI_MODE_RESET;
            st.spd_src <= FF_SRC_RESET;
            st.trq_src <= FF_SRC_RESET;
            st.trq_var <= TQ_VAR_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign p_only_ctrl = st.p_only;
    assign speed_ff_out = st.spd_ff;
    assign torque_ff_out = st.trq_ff;
    assign active_pi_mode = st.pi_mode;
    assign active_speed_src = st.spd_src;
    assign active_torque_src = st.trq_src;

    property p_fixed_pi;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.pi_mode == PI_MODE_FIXED) |=> !p_only_ctrl;
    endproperty
    a_fixed_pi: assert property (p_fixed_pi) else $error("P control in fixed PI mode");

    property p_torque_cmp;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.pi_mode == PI_MODE_TORQUE && !restart && !torque_ref[31])
        |=> (p_only_ctrl == ($unsigned($past(torque_ref)) > $past(torque_ref_switch_threshold)));
    endproperty
    a_torque_cmp: assert property (p_torque_cmp) else $error("Torque compare wrong");

    property p_dev_cmp;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.pi_mode == PI_MODE_DEVIATION && !restart && !deviation_count[31] && deviation_count > 0
            && 32'(deviation_count) > deviation_switch_threshold) |=> p_only_ctrl;
    endproperty
    a_dev_cmp: assert property (p_dev_cmp) else $error("Deviation above threshold not P");

    property p_accel_cmp;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.pi_mode == PI_MODE_ACCEL && !restart && accel_ref == 32'sh00000000) |=> !p_only_ctrl;
    endproperty
    a_accel_cmp: assert property (p_accel_cmp) else $error("Zero acceleration gave P");

    property p_speed_cmp;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.pi_mode == PI_MODE_SPEED && !restart && speed_ref == 32'sh00000000) |=> !p_only_ctrl;
    endproperty
    a_speed_cmp: assert property (p_speed_cmp) else $error("Zero speed reference gave P");

    property p_latch;
        @(posedge ref_clk) disable iff (!rst_n)
        !restart |=> $stable(active_pi_mode) && $stable(active_speed_src) && $stable(active_torque_src);
    endproperty
    a_latch: assert property (p_latch) else $error("Selection changed without restart");

    property p_host_speed;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.spd_src == FF_SRC_HOST && !restart) |=> speed_ff_out == $past(host_velocity_offset);
    endproperty
    a_host_speed: assert property (p_host_speed) else $error("Host speed offset not passed");

    property p_host_torque;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.trq_src == FF_SRC_HOST && !restart) |=> torque_ff_out == 32'($past(host_torque_offset));
    endproperty
    a_host_torque: assert property (p_host_torque) else $error("Host torque offset not passed");

    property p_cubic_gate;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.spd_src == FF_SRC_CUBIC && !restart && interp_sub_mode != INTERP_CUBIC) |=> speed_ff_out == 32'sh0;
    endproperty
    a_cubic_gate: assert property (p_cubic_gate) else $error("Cubic source used without sub-mode");

    property p_undef_mode;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.pi_mode > PI_MODE_FIXED) |=> !p_only_ctrl;
    endproperty
    a_undef_mode: assert property (p_undef_mode) else $error("P control in undefined switch mode");

    property p_dev_below;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.pi_mode == PI_MODE_DEVIATION && !deviation_count[31]
            && $unsigned(deviation_count) <= deviation_switch_threshold) |=> !p_only_ctrl;
    endproperty
    a_dev_below: assert property (p_dev_below) else $error("Deviation within threshold gave P");

    property p_accel_above;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.pi_mode == PI_MODE_ACCEL && !accel_ref[31]
            && $unsigned(accel_ref) > accel_ref_switch_threshold) |=> p_only_ctrl;
    endproperty
    a_accel_above: assert property (p_accel_above) else $error("Acceleration above threshold not P");

    property p_speed_above;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.pi_mode == PI_MODE_SPEED && !speed_ref[31]
            && $unsigned(speed_ref) > speed_ref_switch_threshold) |=> p_only_ctrl;
    endproperty
    a_speed_above: assert property (p_speed_above) else $error("Speed above threshold not P");

    property p_model_gate;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.spd_src == FF_SRC_MODEL && st.mf_en == 2'h0) |=> speed_ff_out == 32'sh0;
    endproperty
    a_model_gate: assert property (p_model_gate) else $error("Model speed used while disabled");

    property p_model_speed;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.spd_src == FF_SRC_MODEL && st.mf_en != 2'h0) |=> speed_ff_out == $past(model_speed_ff);
    endproperty
    a_model_speed: assert property (p_model_speed) else $error("Model speed not passed");

    property p_model_torque;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.trq_src == FF_SRC_MODEL && st.mf_en != 2'h0) |=> torque_ff_out == $past(model_torque_ff);
    endproperty
    a_model_torque: assert property (p_model_torque) else $error("Model torque not passed");

    property p_cubic_speed;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.spd_src == FF_SRC_CUBIC && cubic_ok) |=> speed_ff_out == $past(cubic_speed_ff);
    endproperty
    a_cubic_speed: assert property (p_cubic_speed) else $error("Cubic speed not passed");

    property p_cubic_torque_gate;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.trq_src == FF_SRC_CUBIC && !cubic_ok) |=> torque_ff_out == 32'sh0;
    endproperty
    a_cubic_torque_gate: assert property (p_cubic_torque_gate) else $error("Cubic torque without sub-mode");

    property p_int_speed;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.spd_src == FF_SRC_INTERNAL) |=> speed_ff_out == $past(spd_int);
    endproperty
    a_int_speed: assert property (p_int_speed) else $error("Internal speed path not passed");

    property p_int_torque;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.trq_src == FF_SRC_INTERNAL) |=> torque_ff_out == $past(trq_int);
    endproperty
    a_int_torque: assert property (p_int_torque) else $error("Internal torque path not passed");

    property p_latch_take;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.state == CFG_LATCH) |-> active_pi_mode == $past(p_pi_switch_mode_sel)
            && active_speed_src == $past(speed_ff_source_sel) && active_torque_src == $past(torque_ff_source_sel);
    endproperty
    a_latch_take: assert property (p_latch_take) else $error("Selection not taken at restart");
endmodule

// file: common/ff_sel_pkg.sv
// Package with modes, defaults and widths for the P/PI switch and feedforward selector
package ff_sel_pkg;
    localparam int DATA_W = 32;
    localparam int GAIN_W = 16;
    localparam int TORQ_W = 16;
    localparam int SHIFT_GAIN = 7;
    localparam int FILT_W = 8;
    localparam logic [2:0] PI_MODE_TORQUE = 3'h0;
    localparam logic [2:0] PI_MODE_DEVIATION = 3'h1;
    localparam logic [2:0] PI_MODE_ACCEL = 3'h2;
    localparam logic [2:0] PI_MODE_SPEED = 3'h3;
    localparam logic [2:0] PI_MODE_FIXED = 3'h4;
    localparam logic [1:0] FF_SRC_INTERNAL = 2'h0;
    localparam logic [1:0] FF_SRC_MODEL = 2'h1;
    localparam logic [1:0] FF_SRC_HOST = 2'h2;
    localparam logic [1:0] FF_SRC_CUBIC = 2'h3;
    localparam logic [1:0] TQ_VAR_GENERAL = 2'h0;
    localparam logic [1:0] TQ_VAR_HIGHSPEED = 2'h2;
    localparam logic [15:0] INTERP_CUBIC = 16'hFFFF;
    localparam logic [31:0] TORQUE_THRESH_RESET = 32'h000000C8;
    localparam logic [2:0] PI_MODE_RESET = 3'h0;
    localparam logic [1:0] FF_SRC_RESET = 2'h0;
    localparam logic [1:0] TQ_VAR_RESET = 2'h0;
    typedef enum logic [0:0] {
        CFG_RUN = 1'b0,
        CFG_LATCH = 1'b1
    } cfg_state_t;
endpackage

// file: common/ff_path_if.sv
// Interface between the top and one feedforward differentiate-gain-filter path
`timescale 1ns/1ps
interface ff_path_if;
    logic signed [31:0] ref_in;
    logic [15:0] gain;
    logic [15:0] scale;
    logic [7:0] filter_shift;
    logic sample;
    logic signed [31:0] ff_out;
    modport path (input ref_in, gain, scale, filter_shift, sample, output ff_out);
    modport user (output ref_in, gain, scale, filter_shift, sample, input ff_out);
endinterface

// file: rtl/ff_path.sv
// Differentiator, gain scaler and first-order low-pass filter for one feedforward path
`timescale 1ns/1ps
module ff_path
    import ff_sel_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Path signals
    ff_path_if.path p
);
    typedef struct packed {
        logic signed [31:0] prev_ref;
        logic signed [47:0] acc;
        logic signed [31:0] out;
    } path_state_t;

    path_state_t st;
    path_state_t next_st;
    logic signed [31:0] diff;
    logic signed [63:0] prod;
    logic signed [47:0] scaled;
    logic [4:0] sh;

    always_comb begin
        next_st = st;
        diff = p.ref_in - st.prev_ref;
        // Gain and scale are percentage-like; the product is renormalised by a fixed shift
        prod = (64'(diff) * $signed({1'b0, p.gain}) * $signed({1'b0, p.scale})) >>> (2 * SHIFT_GAIN);
        scaled = prod[47:0];
        // Larger filter time means a larger shift and slower, smoother output
        sh = (p.filter_shift > 8'h10) ? 5'h10 : p.filter_shift[4:0];
        if (p.sample) begin
            next_st.prev_ref = p.ref_in;
            next_st.acc = st.acc + ((scaled - st.acc) >>> sh);
            next_st.out = st.acc[31:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign p.ff_out = st.out;
endmodule

// file: rtl/pi_switch.sv
// Comparator choosing proportional or proportional-integral speed control
`timescale 1ns/1ps
module pi_switch
    import ff_sel_pkg::*;
(
    // Inputs
    input wire logic [2:0] mode,
    input wire logic signed [31:0] torque_ref,
    input wire logic signed [31:0] deviation,
    input wire logic signed [31:0] accel_ref,
    input wire logic signed [31:0] speed_ref,
    input wire logic [31:0] t_torque,
    input wire logic [31:0] t_dev,
    input wire logic [31:0] t_accel,
    input wire logic [31:0] t_speed,
    // Result
    output logic p_only
);
    function automatic logic [31:0] mag(input logic signed [31:0] v);
        mag = v[31] ? 32'(-v) : 32'(v);
    endfunction

    always_comb begin
        case (mode)
            PI_MODE_TORQUE: p_only = mag(torque_ref) > t_torque;
            PI_MODE_DEVIATION: p_only = mag(deviation) > t_dev;
            PI_MODE_ACCEL: p_only = mag(accel_ref) > t_accel;
            PI_MODE_SPEED: p_only = mag(speed_ref) > t_speed;
            PI_MODE_FIXED: p_only = 1'b0;
            default: p_only = 1'b0;
        endcase
    end
endmodule

// file: tb/host_ctrl_model.sv
// Host motion controller model: writes the offset objects and the interpolation sub-mode
`timescale 1ns/1ps
module host_ctrl_model (
    // Clock
    input wire logic ref_clk,
    // Write request: 1 velocity offset, 2 torque offset, 3 sub-mode (service write only)
    input wire logic [1:0] op,
    input wire logic signed [31:0] val,
    // Object values seen by the drive
    output logic signed [31:0] velocity_offset,
    output logic signed [15:0] torque_offset,
    output logic [15:0] sub_mode
);
    initial begin
        velocity_offset = 32'h00000000;
        torque_offset = 16'h0000;
        sub_mode = 16'h0000;
    end
    always @(posedge ref_clk) begin
        case (op)
            2'h1: velocity_offset <= val;
            2'h2: torque_offset <= val[15:0];
            2'h3: sub_mode <= val[15:0];
            default: ;
        endcase
    end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the P/PI switch and feedforward source selector
`timescale 1ns/1ps
module tb_top;
    import ff_sel_pkg::*;
    logic ref_clk, rst_n, restart, sample;
    logic [2:0] mode_sel, act_mode;
    logic [1:0] spd_src, trq_src, variant, mf_en, host_op, act_spd, act_trq;
    logic [31:0] thr_t, thr_d, thr_a, thr_s;
    logic [15:0] spd_gain, trq_gain, inertia, sub_mode;
    logic [7:0] spd_filt, trq_filt;
    logic signed [31:0] trq_ref, dev_cnt, acc_ref, spd_ref, pos_ref, host_val;
    logic signed [31:0] mdl_spd, mdl_trq, cub_spd, cub_trq, vel_off, spd_ff, trq_ff;
    logic signed [15:0] trq_off;
    logic p_only;
    int err_total, checked, cyc;

    servo_pi_switch_feedforward_sel u_servo_pi_switch_feedforward_sel (
        .ref_clk(ref_clk), .rst_n(rst_n), .restart(restart), .sample(sample),
        .p_pi_switch_mode_sel(mode_sel), .speed_ff_source_sel(spd_src), .torque_ff_source_sel(trq_src),
        .torque_ff_variant_sel(variant), .model_follow_enable_sel(mf_en),
        .torque_ref_switch_threshold(thr_t), .deviation_switch_threshold(thr_d),
        .accel_ref_switch_threshold(thr_a), .speed_ref_switch_threshold(thr_s),
        .speed_ff_gain(spd_gain), .speed_ff_filter_time(spd_filt), .torque_ff_gain(trq_gain),
        .torque_ff_filter_time(trq_filt), .load_inertia_pct(inertia), .torque_ref(trq_ref),
        .deviation_count(dev_cnt), .accel_ref(acc_ref), .speed_ref(spd_ref), .position_ref(pos_ref),
        .model_speed_ff(mdl_spd), .model_torque_ff(mdl_trq), .host_velocity_offset(vel_off),
        .host_torque_offset(trq_off), .cubic_speed_ff(cub_spd), .cubic_torque_ff(cub_trq),
        .interp_sub_mode(sub_mode), .p_only_ctrl(p_only), .speed_ff_out(spd_ff), .torque_ff_out(trq_ff),
        .active_pi_mode(act_mode), .active_speed_src(act_spd), .active_torque_src(act_trq));

    host_ctrl_model u_host_ctrl_model (
        .ref_clk(ref_clk), .op(host_op), .val(host_val),
        .velocity_offset(vel_off), .torque_offset(trq_off), .sub_mode(sub_mode));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("counts: checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Selections only land while restart is high, so every mode change goes through here
    task automatic reboot(input logic [2:0] m, input logic [1:0] s, input logic [1:0] t);
        mode_sel = m;
        spd_src = s;
        trq_src = t;
        restart = 1'b1;
        tick(1);
        restart = 1'b0;
        tick(2);
    endtask

    task automatic host_wr(input logic [1:0] op, input logic signed [31:0] v);
        host_op = op;
        host_val = v;
        tick(1);
        host_op = 2'h0;
        tick(2);
    endtask

    // Unselected quantities sit far above threshold so a wrong selection shows up
    task automatic set_q(input int m, input logic signed [31:0] v);
        trq_ref = 32'h10000000;
        dev_cnt = 32'h10000000;
        acc_ref = 32'h10000000;
        spd_ref = 32'h10000000;
        case (m)
            0: trq_ref = v;
            1: dev_cnt = v;
            2: acc_ref = v;
            3: spd_ref = v;
            default: ;
        endcase
        tick(2);
    endtask

    task automatic ramp(input int n, input int dp, input int ds, input int da);
        repeat (n) begin
            sample = 1'b1;
            pos_ref = pos_ref + dp;
            spd_ref = spd_ref + ds;
            acc_ref = acc_ref + da;
            tick(1);
            sample = 1'b0;
            tick(1);
        end
    endtask

    task automatic test_pi_modes;
        chk({29'h0, act_mode}, {29'h0, PI_MODE_RESET});
        for (int m = 0; m < 4; m++) begin
            reboot(m[2:0], FF_SRC_INTERNAL, FF_SRC_INTERNAL);
            chk({29'h0, act_mode}, m);
            set_q(m, 32'sd200);
            chk({31'h0, p_only}, 32'h0);
            set_q(m, 32'sd201);
            chk({31'h0, p_only}, 32'h1);
            set_q(m, -32'sd201);
            chk({31'h0, p_only}, 32'h1);
            set_q(m, 32'sd0);
            chk({31'h0, p_only}, 32'h0);
        end
        reboot(PI_MODE_FIXED, FF_SRC_INTERNAL, FF_SRC_INTERNAL);
        set_q(7, 32'sd0);
        chk({31'h0, p_only}, 32'h0);
        // Undefined switch modes must fall back to PI
        reboot(3'h5, FF_SRC_INTERNAL, FF_SRC_INTERNAL);
        set_q(7, 32'sd0);
        chk({31'h0, p_only}, 32'h0);
        $display("test pi_modes done");
    endtask

    task automatic test_latch;
        reboot(PI_MODE_TORQUE, FF_SRC_INTERNAL, FF_SRC_INTERNAL);
        mode_sel = PI_MODE_FIXED;
        spd_src = FF_SRC_HOST;
        set_q(7, 32'sd0);
        chk({29'h0, act_mode}, {29'h0, PI_MODE_TORQUE});
        chk({30'h0, act_spd}, {30'h0, FF_SRC_INTERNAL});
        chk({31'h0, p_only}, 32'h1);
        thr_t = 32'h7FFFFFFF;
        tick(2);
        chk({31'h0, p_only}, 32'h0);
        thr_t = TORQUE_THRESH_RESET;
        $display("test latch done");
    endtask

    task automatic test_sources;
        mdl_spd = 32'h12345678;
        mdl_trq = 32'hFEDC0001;
        cub_spd = 32'h0BADC0DE;
        cub_trq = 32'h80000007;
        reboot(PI_MODE_FIXED, FF_SRC_MODEL, FF_SRC_MODEL);
        chk(spd_ff, 32'h0);
        mf_en = 2'h1;
        reboot(PI_MODE_FIXED, FF_SRC_MODEL, FF_SRC_MODEL);
        chk(spd_ff, mdl_spd);
        chk(trq_ff, mdl_trq);
        reboot(PI_MODE_FIXED, FF_SRC_HOST, FF_SRC_HOST);
        host_wr(2'h1, 32'h80000001);
        host_wr(2'h2, 32'h00008005);
        chk({30'h0, act_trq}, {30'h0, FF_SRC_HOST});
        chk(spd_ff, 32'h80000001);
        chk(trq_ff, 32'hFFFF8005);
        reboot(PI_MODE_FIXED, FF_SRC_CUBIC, FF_SRC_CUBIC);
        chk(spd_ff, 32'h0);
        chk(trq_ff, 32'h0);
        host_wr(2'h3, {16'h0, INTERP_CUBIC});
        chk(spd_ff, cub_spd);
        chk(trq_ff, cub_trq);
        $display("test sources done");
    endtask

    task automatic test_internal;
        reboot(PI_MODE_FIXED, FF_SRC_INTERNAL, FF_SRC_INTERNAL);
        ramp(6, 1000, 300, 0);
        chk(spd_ff, 32'd1000);
        chk(trq_ff, 32'd300);
        spd_gain = 16'h0040;
        inertia = 16'h0040;
        ramp(6, 1000, 300, 0);
        chk(spd_ff, 32'd500);
        chk(trq_ff, 32'd150);
        spd_filt = 8'h04;
        ramp(2, 3000, 300, 0);
        chk({31'h0, (spd_ff > 500) && (spd_ff < 1500)}, 32'h1);
        ramp(200, 3000, 300, 0);
        chk({31'h0, (spd_ff > 1484) && (spd_ff <= 1500)}, 32'h1);
        inertia = 16'h0080;
        variant = TQ_VAR_HIGHSPEED;
        reboot(PI_MODE_FIXED, FF_SRC_INTERNAL, FF_SRC_INTERNAL);
        ramp(6, 0, 300, 400);
        chk(trq_ff, 32'd500);
        $display("test internal done");
    endtask

    // Cuts a hang short well beyond the roughly 530 cycles the tests need
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        {restart, sample, mode_sel, spd_src, trq_src, variant, mf_en, host_op} = '0;
        {thr_d, thr_a, thr_s} = {3{32'h000000C8}};
        thr_t = TORQUE_THRESH_RESET;
        {spd_gain, trq_gain, inertia} = {3{16'h0080}};
        {spd_filt, trq_filt} = '0;
        {trq_ref, dev_cnt, acc_ref, spd_ref, pos_ref, host_val} = '0;
        {mdl_spd, mdl_trq, cub_spd, cub_trq} = '0;
        rst_n = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        tick(1);
        test_pi_modes();
        test_latch();
        test_sources();
        test_internal();
        close_out();
    end
endmodule
